// [inc/ecs_pkg.sv]
package ecs_pkg;
   localparam int ECS_NWIN = 8;
   localparam int ECS_AMP_W = 12;
   localparam int ECS_CNT_W = 32;
   localparam int ECS_CH_W = 13;
   localparam logic [31:0] ECS_CNT_ONE = 32'h0000_0001;
   localparam logic [12:0] ECS_CH_ONE = 13'h0001;
   localparam logic [12:0] ECS_CH_TOP_RST = 13'h03ff;
   localparam logic [11:0] ECS_WIN_LO_RST = 12'h000;
   localparam logic [11:0] ECS_WIN_HI_RST = 12'hfff;
   localparam logic [31:0] ECS_TB_RST = 32'h000f_4240;
   // axi byte offsets
   localparam logic [7:0] ECS_A_CTRL = 8'h00;
   localparam logic [7:0] ECS_A_STAT = 8'h04;
   localparam logic [7:0] ECS_A_IRQ_ST = 8'h08;
   localparam logic [7:0] ECS_A_IRQ_MASK = 8'h0c;
   localparam logic [7:0] ECS_A_PRESET = 8'h10;
   localparam logic [7:0] ECS_A_TBASE = 8'h14;
   localparam logic [7:0] ECS_A_CHTOP = 8'h18;
   localparam logic [7:0] ECS_A_SNAP = 8'h1c;
   localparam logic [7:0] ECS_A_FAST = 8'h20;
   localparam logic [7:0] ECS_A_ACC = 8'h24;
   localparam logic [7:0] ECS_A_REJ = 8'h28;
   localparam logic [7:0] ECS_A_EXT = 8'h2c;
   localparam logic [7:0] ECS_A_ROI = 8'h30;
   localparam logic [7:0] ECS_A_TIME = 8'h34;
   localparam logic [7:0] ECS_A_WIN = 8'h40;
   // ctrl bits
   localparam int ECS_C_RUN = 0;
   localparam int ECS_C_SCALER = 1;
   localparam int ECS_C_PRESET = 2;
   localparam int ECS_C_CLEAR = 3;
   // irq bits
   localparam int ECS_I_PRESET = 0;
   localparam int ECS_I_BIN = 1;
   localparam int ECS_I_SNAP = 2;
   localparam int ECS_I_W = 3;
   localparam logic [1:0] ECS_RESP_OK = 2'b00;
   localparam logic [1:0] ECS_RESP_ERR = 2'b10;
   typedef enum logic [1:0] {
      ECS_IDLE = 2'b00,
      ECS_RUN = 2'b01,
      ECS_STOP = 2'b11
   } ecs_acq_t;
   function automatic logic [31:0] ecs_inc(input logic [31:0] v, input logic en);
      ecs_inc = en ? v + ECS_CNT_ONE : v;
   endfunction : ecs_inc
endpackage : ecs_pkg

// [inc/ecs_win_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface ecs_win_if;
   logic [ecs_pkg::ECS_NWIN-1:0][ecs_pkg::ECS_AMP_W-1:0] lo;
   logic [ecs_pkg::ECS_NWIN-1:0][ecs_pkg::ECS_AMP_W-1:0] hi;
   logic [ecs_pkg::ECS_AMP_W-1:0] amp;
   logic accept;
   logic [ecs_pkg::ECS_NWIN-1:0] hit;
   modport ctrl (output lo, output hi, output amp, output accept, input hit);
   modport win (input lo, input hi, input amp, input accept, output hit);
endinterface : ecs_win_if
`default_nettype wire

// [verif/ecs_front_model.sv]
`timescale 1ns/1ns
`default_nettype none
module ecs_front_model (
   input wire logic clock_in,
   output logic fast_event_out,
   output logic peak_event_out,
   output logic [11:0] peak_amp_out,
   output logic [12:0] peak_ch_out,
   output logic pile_up_rejection_out,
   output logic risetime_discrimination_out
);
   initial begin
      fast_event_out = 1'b0;
      peak_event_out = 1'b0;
      peak_amp_out = 12'h5a5;
      peak_ch_out = 13'h0a5a;
      pile_up_rejection_out = 1'b1;
      risetime_discrimination_out = 1'b1;
   end
   // fast trigger leads the peak, as the shorter shaping fires first
   task automatic shot(input logic [11:0] a, input logic [12:0] c, input logic pu, input logic rt);
      fast_event_out <= 1'b1;
      @(posedge clock_in);
      fast_event_out <= 1'b0;
      repeat (2) @(posedge clock_in);
      peak_event_out <= 1'b1;
      peak_amp_out <= a;
      peak_ch_out <= c;
      pile_up_rejection_out <= pu;
      risetime_discrimination_out <= rt;
      @(posedge clock_in);
      peak_event_out <= 1'b0;
      // qualifiers scrambled once released, so late sampling shows
      peak_amp_out <= ~a;
      peak_ch_out <= ~c;
      pile_up_rejection_out <= ~pu;
      risetime_discrimination_out <= ~rt;
   endtask : shot
endmodule : ecs_front_model
`default_nettype wire

// [verif/ecs_top_props.sv]
`timescale 1ns/1ns
`default_nettype none
module ecs_top_props (
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic peak_event_in,
   input wire logic [ecs_pkg::ECS_CH_W-1:0] peak_ch_in,
   input wire logic pile_up_rejection_in,
   input wire logic risetime_discrimination_in,
   input wire logic gate_ok_in,
   input wire logic preamp_reset_in,
   input wire logic transfer_busy_in,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [ecs_pkg::ECS_NWIN-1:0] window_pulse_out,
   input wire logic hist_amp_we_out,
   input wire logic hist_scaler_we_out,
   input wire logic [ecs_pkg::ECS_CH_W-1:0] hist_ch_out,
   input wire logic [31:0] hist_data_out,
   input wire logic acquiring_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_win_cause: assert property (|window_pulse_out |-> $past(peak_event_in &&
      !pile_up_rejection_in && !risetime_discrimination_in)) else $error("window pulse no cause");
   a_amp_accept: assert property (hist_amp_we_out |-> $past(peak_event_in &&
      !pile_up_rejection_in && !risetime_discrimination_in && gate_ok_in && !preamp_reset_in &&
      !transfer_busy_in && acquiring_out)) else $error("histogram write not accepted");
   a_amp_chan: assert property (hist_amp_we_out |-> hist_ch_out == $past(peak_ch_in) &&
      hist_data_out == 32'h0000_0000) else $error("histogram channel wrong");
   a_mode_excl: assert property (hist_amp_we_out |-> !hist_scaler_we_out)
      else $error("both histogram modes");
   a_scaler_run: assert property (hist_scaler_we_out |-> $past(acquiring_out) &&
      hist_ch_out != 13'h0000) else $error("scaler bin outside run");
   a_wr_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
      else $error("no write response");
   a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid) else $error("no read response");
   a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
endmodule : ecs_top_props
bind ecs_top ecs_top_props u_props (.clock_in, .rst_b_in, .peak_event_in, .peak_ch_in,
   .pile_up_rejection_in, .risetime_discrimination_in, .gate_ok_in, .preamp_reset_in,
   .transfer_busy_in, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .window_pulse_out,
   .hist_amp_we_out, .hist_scaler_we_out, .hist_ch_out, .hist_data_out, .acquiring_out);
`default_nettype wire

// [verif/ecs_top_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module ecs_top_tb;
   import ecs_pkg::*;
   logic clock_in, rst_b_in, gate_ok_in, preamp_reset_in, transfer_busy_in, ext_pulse_in;
   logic fast, peak, pile_up_rejection, risetime_discrimination, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, amp_we, sc_we, acq, irq;
   logic [11:0] amp;
   logic [12:0] ch, hch;
   logic [7:0] awa, ara, wpul;
   logic [31:0] wd, rd, hd, t1, t2, d;
   logic [1:0] bresp, rresp, r;
   logic [3:0] ws;
   logic [44:0] sq[$];
   int error_cnt, checks_done, amp_cnt, a0;
   logic [11:0] ta[8] = '{12'h000, 12'h1ff, 12'h700, 12'h7ff, 12'h350, 12'h720, 12'h800, 12'h900};
   logic [7:0] ca[5] = '{ECS_A_FAST, ECS_A_ACC, ECS_A_REJ, ECS_A_EXT, ECS_A_ROI};
   logic [31:0] ce[5] = '{32'h8, 32'h5, 32'h2, 32'h3, 32'h2};
   ecs_front_model fe (.clock_in(clock_in), .fast_event_out(fast), .peak_event_out(peak),
      .peak_amp_out(amp), .peak_ch_out(ch), .pile_up_rejection_out(pile_up_rejection),
      .risetime_discrimination_out(risetime_discrimination));
   ecs_top dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .fast_event_in(fast),
      .peak_event_in(peak), .peak_amp_in(amp), .peak_ch_in(ch), .pile_up_rejection_in(pile_up_rejection),
      .risetime_discrimination_in(risetime_discrimination), .gate_ok_in(gate_ok_in), .preamp_reset_in(preamp_reset_in),
      .transfer_busy_in(transfer_busy_in), .ext_pulse_in(ext_pulse_in), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr),
      .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
      .window_pulse_out(wpul), .hist_amp_we_out(amp_we), .hist_scaler_we_out(sc_we),
      .hist_ch_out(hch), .hist_data_out(hd), .acquiring_out(acq), .irq_out(irq));
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   // pulses stood in the cycle before this edge
   always @(posedge clock_in) begin
      if (sc_we === 1'b1) sq.push_back({hch, hd});
      if (amp_we === 1'b1) amp_cnt++;
   end
   task automatic end_of_test;
      if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   // handshakes sampled at the rising edge, before the design's registers move
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
      awa <= a; wd <= v; ws <= 4'hf; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
      do begin
         @(posedge clock_in);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr) wv <= 1'b0;
      end while (!bv);
      r = bresp;
   endtask : axi_wr
   // ready lines stay up between calls, so no edge sees them dropped and raised
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v);
      ara <= a; arv <= 1'b1; rr <= 1'b1;
      do begin
         @(posedge clock_in);
         if (arv && arr) arv <= 1'b0;
      end while (!rv);
      v = rd;
      r = rresp;
   endtask : axi_rd
   function automatic logic [7:0] wmask(input logic [11:0] a, input logic rej);
      for (int n = 0; n < ECS_NWIN; n++) wmask[n] = !rej && a[11:8] == 4'(n);
   endfunction : wmask
   task automatic ev(input logic [11:0] a, input logic [12:0] c, input logic pu, input logic rt);
      fe.shot(a, c, pu, rt);
      @(negedge clock_in);
      chk({24'h0, wpul}, {24'h0, wmask(a, pu | rt)}, "window pulse");
      @(posedge clock_in);
   endtask : ev
   task automatic ext(input int k);
      repeat (k) begin
         ext_pulse_in <= 1'b1;
         repeat (2) @(posedge clock_in);
         ext_pulse_in <= 1'b0;
         repeat (2) @(posedge clock_in);
      end
   endtask : ext
   initial begin
      #400000;
      error_cnt++;
      end_of_test();
   end
   initial begin
      rst_b_in = 1'b0; gate_ok_in = 1'b1; preamp_reset_in = 1'b0; transfer_busy_in = 1'b0;
      ext_pulse_in = 1'b0; awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0; rr = 1'b0;
      awa = 8'h00; ara = 8'h00; wd = 32'h0; ws = 4'h0;
      repeat (5) @(posedge clock_in);
      rst_b_in <= 1'b1;
      @(posedge clock_in);
      for (int n = 0; n < ECS_NWIN; n++)
         axi_wr(ECS_A_WIN + 8'(4 * n), {4'h0, 4'(n), 8'hff, 4'h0, 4'(n), 8'h00});
      chk({30'h0, r}, {30'h0, ECS_RESP_OK}, "write resp");
      axi_wr(ECS_A_CTRL, 32'h1);
      for (int i = 0; i < 8; i++) ev(ta[i], i == 7 ? 13'h0500 : {3'h0, ta[i][11:2]}, i == 4, i == 5);
      // fast and peak both blocked by each inhibit in turn
      for (int k = 0; k < 3; k++) begin
         {gate_ok_in, preamp_reset_in, transfer_busy_in} <= 3'b100 ^ (3'b100 >> k);
         fe.shot(12'h050, 13'h0014, 1'b0, 1'b0);
         repeat (2) @(posedge clock_in);
         {gate_ok_in, preamp_reset_in, transfer_busy_in} <= 3'b100;
         @(posedge clock_in);
      end
      gate_ok_in <= 1'b0;
      axi_wr(ECS_A_SNAP, 32'h0);
      axi_rd(ECS_A_TIME, t1);
      repeat (20) @(posedge clock_in);
      axi_wr(ECS_A_SNAP, 32'h0);
      axi_rd(ECS_A_TIME, t2);
      chk(t2, t1, "time while gated");
      gate_ok_in <= 1'b1;
      repeat (20) @(posedge clock_in);
      axi_wr(ECS_A_SNAP, 32'h0);
      axi_rd(ECS_A_TIME, t1);
      chk({31'h0, t1 !== t2}, 32'h1, "time runs");
      ext(3);
      axi_wr(ECS_A_CTRL, 32'h0);
      ext(2);
      fe.shot(12'h700, 13'h01c0, 1'b0, 1'b0);
      repeat (2) @(posedge clock_in);
      axi_wr(ECS_A_SNAP, 32'h0);
      for (int i = 0; i < 5; i++) begin
         axi_rd(ca[i], d);
         chk(d, ce[i], "counter");
      end
      chk(32'(amp_cnt), 32'h5, "histogram writes");
      axi_rd(8'h3c, d);
      chk({30'h0, r}, {30'h0, ECS_RESP_ERR}, "unmapped resp");
      axi_wr(ECS_A_CTRL, 32'h8);
      axi_wr(ECS_A_PRESET, 32'h2);
      axi_wr(ECS_A_CTRL, 32'h5);
      ev(12'h7a0, 13'h01e8, 1'b0, 1'b0);
      ev(12'h7a0, 13'h01e8, 1'b0, 1'b0);
      for (int i = 0; i < 20 && acq !== 1'b0; i++) @(posedge clock_in);
      @(negedge clock_in);
      chk({31'h0, acq}, 32'h0, "preset stop");
      chk({31'h0, irq}, 32'h0, "irq masked");
      @(posedge clock_in);
      axi_wr(ECS_A_IRQ_MASK, 32'h1);
      @(negedge clock_in);
      chk({31'h0, irq}, 32'h1, "irq raised");
      @(posedge clock_in);
      axi_rd(ECS_A_IRQ_ST, d);
      chk(d & 32'h1, 32'h1, "preset status");
      @(negedge clock_in);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      @(posedge clock_in);
      axi_wr(ECS_A_CTRL, 32'ha);
      axi_wr(ECS_A_TBASE, 32'd200);
      axi_wr(ECS_A_CHTOP, 32'h3);
      a0 = amp_cnt;
      axi_wr(ECS_A_CTRL, 32'h3);
      ev(12'h780, 13'h01e0, 1'b0, 1'b0);
      ev(12'h780, 13'h01e0, 1'b0, 1'b0);
      for (int i = 0; i < 400 && sq.size() < 1; i++) @(posedge clock_in);
      ev(12'h780, 13'h01e0, 1'b0, 1'b0);
      for (int i = 0; i < 800 && sq.size() < 3; i++) @(posedge clock_in);
      chk(32'(sq.size()), 32'h3, "bin count");
      for (int i = 0; i < 3 && i < sq.size(); i++) begin
         chk({19'h0, sq[i][44:32]}, 32'(i + 1), "bin channel");
         chk(sq[i][31:0], 32'(2 - i + (i == 2)) - 32'(i == 2), "bin total");
      end
      chk(32'(amp_cnt), 32'(a0), "no amplitude writes in scaler");
      axi_rd(ECS_A_STAT, d);
      chk(d, 32'h7, "scaler full stop");
      end_of_test();
   end
endmodule : ecs_top_tb
`default_nettype wire

// [verilog/ecs_scaler.sv]
`timescale 1ns/1ns
`default_nettype none
module ecs_scaler (
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic start_in,
   input wire logic active_in,
   input wire logic event_in,
   input wire logic [31:0] tbase_in,
   input wire logic [12:0] ch_top_in,
   output logic bin_valid_out,
   output logic [12:0] bin_ch_out,
   output logic [31:0] bin_count_out,
   output logic full_out
);
   import ecs_pkg::*;
   typedef struct packed {
      logic [31:0] tick;
      logic [31:0] cnt;
      logic [12:0] ch;
      logic valid;
      logic [12:0] out_ch;
      logic [31:0] out_cnt;
      logic full;
   } ecs_scl_st_t;
   ecs_scl_st_t s_q;
   ecs_scl_st_t s_d;
   always_comb begin
      s_d = s_q;
      s_d.valid = 1'b0;
      if (start_in) begin
         s_d = '0;
         s_d.ch = ECS_CH_ONE;
      end else if (active_in && !s_q.full) begin
         s_d.cnt = ecs_inc(s_q.cnt, event_in);
         if (s_q.tick + ECS_CNT_ONE >= tbase_in) begin
            // interval closes; an event in this cycle joins it
            s_d.valid = 1'b1;
            s_d.out_ch = s_q.ch;
            s_d.out_cnt = ecs_inc(s_q.cnt, event_in);
            s_d.cnt = '0;
            s_d.tick = '0;
            s_d.full = (s_q.ch >= ch_top_in);
            s_d.ch = s_q.ch + ECS_CH_ONE;
         end else begin
            s_d.tick = s_q.tick + ECS_CNT_ONE;
         end
      end
   end
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign bin_valid_out = s_q.valid;
   assign bin_ch_out = s_q.out_ch;
   assign bin_count_out = s_q.out_cnt;
   assign full_out = s_q.full;
endmodule : ecs_scaler
`default_nettype wire

// [verilog/ecs_top.sv]
`timescale 1ns/1ns
`default_nettype none
module ecs_top (
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic fast_event_in,
   input wire logic peak_event_in,
   input wire logic [ecs_pkg::ECS_AMP_W-1:0] peak_amp_in,
   input wire logic [ecs_pkg::ECS_CH_W-1:0] peak_ch_in,
   input wire logic pile_up_rejection_in,
   input wire logic risetime_discrimination_in,
   input wire logic gate_ok_in,
   input wire logic preamp_reset_in,
   input wire logic transfer_busy_in,
   input wire logic ext_pulse_in,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic [ecs_pkg::ECS_NWIN-1:0] window_pulse_out,
   output logic hist_amp_we_out,
   output logic hist_scaler_we_out,
   output logic [ecs_pkg::ECS_CH_W-1:0] hist_ch_out,
   output logic [31:0] hist_data_out,
   output logic acquiring_out,
   output logic irq_out
);
   import ecs_pkg::*;
   typedef struct packed {
      ecs_acq_t acq;
      logic scaler;
      logic preset_en;
      logic [31:0] preset;
      logic [31:0] tbase;
      logic [12:0] ch_top;
      logic [ECS_NWIN-1:0][ECS_AMP_W-1:0] lo;
      logic [ECS_NWIN-1:0][ECS_AMP_W-1:0] hi;
      logic [31:0] fast;
      logic [31:0] acc;
      logic [31:0] rej;
      logic [31:0] ext;
      logic [31:0] region_of_interest;
      logic [31:0] time_cnt;
      logic [5:0][31:0] snap;
      logic ext_prev;
      logic [ECS_I_W-1:0] irq_st;
      logic [ECS_I_W-1:0] irq_mask;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic amp_we;
      logic [12:0] amp_ch;
      logic start_p;
   } ecs_st_t;
   ecs_st_t s_q;
   ecs_st_t s_d;
   logic running;
   logic counting;
   logic accept;
   logic bin_valid;
   logic [12:0] bin_ch;
   logic [31:0] bin_count;
   logic scl_full;
   ecs_win_if win_if ();
   assign running = (s_q.acq == ECS_RUN);
   // acquisition halts during preamp reset and transfer; gate-off is applied per counter, not here, and the ext counter ignores it
   assign counting = running && !preamp_reset_in && !transfer_busy_in;
   assign accept = peak_event_in && gate_ok_in && !pile_up_rejection_in &&
      !risetime_discrimination_in;
   assign win_if.lo = s_q.lo;
   assign win_if.hi = s_q.hi;
   assign win_if.amp = peak_amp_in;
   assign win_if.accept = accept && counting;
   ecs_windows u_win (
      .clock_in(clock_in),
      .rst_b_in(rst_b_in),
      .win_if(win_if)
   );
   ecs_scaler u_scl (
      .clock_in(clock_in),
      .rst_b_in(rst_b_in),
      .start_in(s_q.start_p),
      .active_in(counting && s_q.scaler && gate_ok_in),
      .event_in(win_if.hit[ECS_NWIN-1]),
      .tbase_in(s_q.tbase),
      .ch_top_in(s_q.ch_top),
      .bin_valid_out(bin_valid),
      .bin_ch_out(bin_ch),
      .bin_count_out(bin_count),
      .full_out(scl_full)
   );
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
         input logic [3:0] strb);
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            old[b*8 +: 8] = nv[b*8 +: 8];
         end
      end
      merge = old;
   endfunction : merge
   always_comb begin
      logic [7:0] ra;
      logic [31:0] wv;
      logic stop;
      logic [ECS_I_W-1:0] ev;
      logic rd_irq;
      ra = s_axi_araddr;
      wv = '0;
      stop = 1'b0;
      ev = '0;
      rd_irq = 1'b0;
      s_d = s_q;
      s_d.start_p = 1'b0;
      s_d.ext_prev = ext_pulse_in;
      s_d.amp_we = 1'b0;
      // counters
      s_d.fast = ecs_inc(s_q.fast, counting && fast_event_in && gate_ok_in);
      s_d.rej = ecs_inc(s_q.rej, counting && peak_event_in && gate_ok_in &&
         (pile_up_rejection_in || risetime_discrimination_in));
      s_d.ext = ecs_inc(s_q.ext, counting && ext_pulse_in && !s_q.ext_prev);
      s_d.time_cnt = ecs_inc(s_q.time_cnt, counting && gate_ok_in);
      s_d.region_of_interest = ecs_inc(s_q.region_of_interest, win_if.hit[ECS_NWIN-1]);
      if (counting && accept && !s_q.scaler && peak_ch_in <= s_q.ch_top) begin
         // only channel-range events reach the histogram
         s_d.acc = s_q.acc + ECS_CNT_ONE;
         s_d.amp_we = 1'b1;
         s_d.amp_ch = peak_ch_in;
      end
      if (running && s_q.preset_en && s_q.region_of_interest >= s_q.preset) begin
         stop = 1'b1;
         ev[ECS_I_PRESET] = 1'b1;
      end
      if (running && s_q.scaler && scl_full && !s_q.start_p) begin
         stop = 1'b1;
      end
      if (bin_valid) begin
         ev[ECS_I_BIN] = 1'b1;
      end
      if (stop) begin
         s_d.acq = ECS_STOP;
      end
      // write channel
      if (s_axi_awvalid && !s_q.aw_got) begin
         s_d.aw_got = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_q.w_got) begin
         s_d.w_got = 1'b1;
         s_d.w_data = s_axi_wdata;
         s_d.w_strb = s_axi_wstrb;
      end
      if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = ECS_RESP_OK;
         if (s_q.aw_addr == ECS_A_CTRL) begin
            wv = merge({28'h0, 1'b0, s_q.preset_en, s_q.scaler, running}, s_q.w_data,
               s_q.w_strb);
            s_d.preset_en = wv[ECS_C_PRESET];
            if (!running) begin
               // mode is frozen while acquiring
               s_d.scaler = wv[ECS_C_SCALER];
            end
            if (wv[ECS_C_CLEAR]) begin
               s_d.fast = '0;
               s_d.acc = '0;
               s_d.rej = '0;
               s_d.ext = '0;
               s_d.region_of_interest = '0;
               s_d.time_cnt = '0;
            end
            if (wv[ECS_C_RUN] && !running && !stop) begin
               s_d.acq = ECS_RUN;
               s_d.start_p = 1'b1;
            end else if (!wv[ECS_C_RUN] && running) begin
               s_d.acq = ECS_STOP;
            end
         end else if (s_q.aw_addr == ECS_A_IRQ_MASK) begin
            s_d.irq_mask = ECS_I_W'(merge({29'h0, s_q.irq_mask}, s_q.w_data,
               s_q.w_strb));
         end else if (s_q.aw_addr == ECS_A_PRESET) begin
            s_d.preset = merge(s_q.preset, s_q.w_data, s_q.w_strb);
         end else if (s_q.aw_addr == ECS_A_TBASE) begin
            s_d.tbase = merge(s_q.tbase, s_q.w_data, s_q.w_strb);
         end else if (s_q.aw_addr == ECS_A_CHTOP) begin
            s_d.ch_top = ECS_CH_W'(merge({19'h0, s_q.ch_top}, s_q.w_data, s_q.w_strb));
         end else if (s_q.aw_addr == ECS_A_SNAP) begin
            // one-cycle snapshot keeps the report self-consistent
            s_d.snap = {s_q.time_cnt, s_q.region_of_interest, s_q.ext, s_q.rej, s_q.acc, s_q.fast};
            ev[ECS_I_SNAP] = 1'b1;
         end else if (s_q.aw_addr >= ECS_A_WIN &&
               s_q.aw_addr < ECS_A_WIN + 8'(4 * ECS_NWIN)) begin
            wv = merge({4'h0, s_q.hi[s_q.aw_addr[4:2]], 4'h0, s_q.lo[s_q.aw_addr[4:2]]},
               s_q.w_data, s_q.w_strb);
            s_d.lo[s_q.aw_addr[4:2]] = wv[11:0];
            s_d.hi[s_q.aw_addr[4:2]] = wv[27:16];
         end else if (s_q.aw_addr != ECS_A_STAT && s_q.aw_addr != ECS_A_IRQ_ST &&
               !(s_q.aw_addr >= ECS_A_FAST && s_q.aw_addr <= ECS_A_TIME)) begin
            s_d.bresp = ECS_RESP_ERR;
         end
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      // read channel
      if (s_axi_arvalid && !s_q.rvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = ECS_RESP_OK;
         s_d.rdata = '0;
         if (ra == ECS_A_CTRL) begin
            s_d.rdata = {28'h0, 1'b0, s_q.preset_en, s_q.scaler, running};
         end else if (ra == ECS_A_STAT) begin
            s_d.rdata = {29'h0, scl_full, s_q.acq};
         end else if (ra == ECS_A_IRQ_ST) begin
            s_d.rdata = {29'h0, s_q.irq_st};
            rd_irq = 1'b1;
         end else if (ra == ECS_A_IRQ_MASK) begin
            s_d.rdata = {29'h0, s_q.irq_mask};
         end else if (ra == ECS_A_PRESET) begin
            s_d.rdata = s_q.preset;
         end else if (ra == ECS_A_TBASE) begin
            s_d.rdata = s_q.tbase;
         end else if (ra == ECS_A_CHTOP) begin
            s_d.rdata = {19'h0, s_q.ch_top};
         end else if (ra >= ECS_A_FAST && ra <= ECS_A_TIME) begin
            s_d.rdata = s_q.snap[3'(ra[4:2])];
         end else if (ra >= ECS_A_WIN && ra < ECS_A_WIN + 8'(4 * ECS_NWIN)) begin
            s_d.rdata = {4'h0, s_q.hi[ra[4:2]], 4'h0, s_q.lo[ra[4:2]]};
         end else if (ra != ECS_A_SNAP) begin
            s_d.rresp = ECS_RESP_ERR;
         end
      end
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      // set beats read-clear
      s_d.irq_st = (rd_irq ? '0 : s_q.irq_st) | ev;
   end
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_q <= '0;
         s_q.acq <= ECS_IDLE;
         s_q.tbase <= ECS_TB_RST;
         s_q.ch_top <= ECS_CH_TOP_RST;
         s_q.lo <= {ECS_NWIN{ECS_WIN_LO_RST}};
         s_q.hi <= {ECS_NWIN{ECS_WIN_HI_RST}};
      end else begin
         s_q <= s_d;
      end
   end
   assign s_axi_awready = !s_q.aw_got;
   assign s_axi_wready = !s_q.w_got;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = !s_q.rvalid;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign window_pulse_out = win_if.hit;
   // one writer per mode, never both
   assign hist_amp_we_out = s_q.amp_we && !s_q.scaler;
   assign hist_scaler_we_out = bin_valid && s_q.scaler;
   assign hist_ch_out = s_q.scaler ? bin_ch : s_q.amp_ch;
   assign hist_data_out = s_q.scaler ? bin_count : '0;
   assign acquiring_out = running;
   assign irq_out = |(s_q.irq_st & s_q.irq_mask);
endmodule : ecs_top
`default_nettype wire

// [verilog/ecs_windows.sv]
`timescale 1ns/1ns
`default_nettype none
module ecs_windows (
   input wire logic clock_in,
   input wire logic rst_b_in,
   ecs_win_if.win win_if
);
   import ecs_pkg::*;
   typedef struct packed {
      logic [ECS_NWIN-1:0] hit;
   } ecs_win_st_t;
   ecs_win_st_t s_q;
   ecs_win_st_t s_d;
   always_comb begin
      s_d = s_q;
      for (int i = 0; i < ECS_NWIN; i++) begin
         // each window compares only its own limits
         s_d.hit[i] = win_if.accept && (win_if.amp >= win_if.lo[i]) &&
            (win_if.amp <= win_if.hi[i]);
      end
   end
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign win_if.hit = s_q.hit;
endmodule : ecs_windows
`default_nettype wire
